/* File: include/bca_consts.svh */
// Offsets, field positions, reset values and timing counts of the bias/alarm block
`ifndef BCA_CONSTS_SVH
`define BCA_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte addresses (low byte; high byte is +1)
// ----------------------------------------------------------------------
`define BCA_ADDR_FLASH_WRITE_COUNTER 7'h00
`define BCA_ADDR_RATE_LOW 7'h04
`define BCA_ADDR_RATE_HIGH 7'h06
`define BCA_ADDR_OFF_LOW 7'h08
`define BCA_ADDR_OFF_HIGH 7'h0a
`define BCA_ADDR_ALM1_THR 7'h10
`define BCA_ADDR_ALM2_THR 7'h12
`define BCA_ADDR_ALM1_CNT 7'h14
`define BCA_ADDR_ALM2_CNT 7'h16
`define BCA_ADDR_ALM_CFG 7'h18
`define BCA_ADDR_DIAG 7'h26
`define BCA_ADDR_CMD 7'h28
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BCA_CMD_ABC 0
`define BCA_CMD_RESTORE 1
`define BCA_CMD_FLASH 3
`define BCA_CFG_SRC_LSB 8
`define BCA_CFG_ROC_LSB 6
`define BCA_CFG_POL_LSB 4
`define BCA_CFG_FILT 3
`define BCA_CFG_PIN_EN 2
`define BCA_CFG_PIN_POL 1
`define BCA_CFG_PIN_SEL 0
`define BCA_DIAG_ALM_LSB 8
`define BCA_SRC_OFF 4'h0
`define BCA_SRC_RATE 4'h1
`define BCA_SRC_TEMP 4'h2
`define BCA_SRC_DIAG 4'h3
`define BCA_DEC_MAX 5'h10
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BCA_REG_RESET 16'h0000
`define BCA_FLASH_MS 72
`define BCA_CLK_MHZ 200
`define BCA_FLASH_CYCLES (`BCA_FLASH_MS * 1000 * `BCA_CLK_MHZ)
`endif

/* File: include/bca_pkg.sv */
// Types shared by the bias correction and alarm block
package bca_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ABC_SYNC,
    ST_ABC_AVG,
    ST_ABC_LOAD,
    ST_FLASH
  } bca_state_type;
  typedef logic [15:0] bca_word_type;
endpackage : bca_pkg

/* File: verilog/bca_core.sv */
// Bias correction sequencer, user offset registers and two-channel alarm monitor
`include "bca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module bca_core #(
  parameter int unsigned FLASH_CYCLES = `BCA_FLASH_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Register port from the serial front end (byte writes, word reads)
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_port_busy,
  // Sensor side
  input wire logic i_sample,
  input wire logic i_data_ready,
  input wire logic [4:0] i_decimation_setting,
  input wire logic [31:0] i_rate_cal,
  input wire logic [15:0] i_rate_filt,
  input wire logic [15:0] i_temp,
  input wire logic [15:0] i_diag_in,
  output logic [15:0] o_rate_output_high,
  output logic [15:0] o_rate_output_low,
  output logic o_data_clear,
  output logic o_dec_restart,
  // Flash side
  output logic o_flash_busy,
  output logic o_flash_write,
  // I/O line sharing
  input wire logic i_dready_level,
  input wire logic i_dready_en,
  input wire logic i_dready_sel,
  input wire logic [1:0] i_gpio_out,
  input wire logic [1:0] i_gpio_oe,
  output logic [1:0] o_io_out,
  output logic [1:0] o_io_oe,
  output logic [1:0] o_alarm_flags
);
  import bca_pkg::*;

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  localparam int NREG = 7;
  localparam logic [6:0] REG_ADDR [NREG] = '{`BCA_ADDR_OFF_LOW, `BCA_ADDR_OFF_HIGH,
    `BCA_ADDR_ALM1_THR, `BCA_ADDR_ALM2_THR, `BCA_ADDR_ALM1_CNT, `BCA_ADDR_ALM2_CNT,
    `BCA_ADDR_ALM_CFG};

  bca_state_type state_q;
  bca_word_type regs_q [NREG];
  logic [15:0] flash_write_counter_q;
  logic [23:0] flash_tmr_q;
  logic [16:0] avg_cnt_q;
  logic [31:0] rate_out_q;
  logic [1:0] alarm_q;
  logic [15:0] rdata_q;
  logic [1:0] io_out_q;
  logic [1:0] io_oe_q;
  logic data_clear_q;
  logic dec_restart_q;
  logic flash_write_q;

  wire abc_active = (state_q == ST_ABC_SYNC) || (state_q == ST_ABC_AVG) ||
                    (state_q == ST_ABC_LOAD);
  wire port_open = !abc_active;
  wire wr_ok = i_wr && port_open;
  wire cmd_wr = wr_ok && (i_addr == `BCA_ADDR_CMD) && (state_q == ST_IDLE);
  wire start_abc = cmd_wr && i_wdata[`BCA_CMD_ABC];
  wire start_restore = cmd_wr && !i_wdata[`BCA_CMD_ABC] && i_wdata[`BCA_CMD_RESTORE];
  wire start_flash = cmd_wr && !i_wdata[`BCA_CMD_ABC] && !i_wdata[`BCA_CMD_RESTORE] &&
                     i_wdata[`BCA_CMD_FLASH];

  logic [NREG-1:0] wr_lo;
  logic [NREG-1:0] wr_hi;

  wire [15:0] cfg = regs_q[6];
  wire [15:0] off_hi = regs_q[1];
  wire [15:0] off_lo = regs_q[0];
  // Offset words line up with the two rate output words
  wire [31:0] offset_full = {off_hi, off_lo};
  wire [31:0] abc_value = 32'h0 - rate_out_q;
  wire load_offsets = (state_q == ST_ABC_LOAD);

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign wr_lo[g] = wr_ok && (i_addr == REG_ADDR[g]);
      assign wr_hi[g] = wr_ok && (i_addr == (REG_ADDR[g] + 7'h01));
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          regs_q[g] <= `BCA_REG_RESET;
        end else if (i_ce) begin
          if (g < 2 && load_offsets) begin
            regs_q[g] <= (g == 0) ? abc_value[15:0] : abc_value[31:16];
          end else if (g < 2 && start_restore) begin
            regs_q[g] <= `BCA_REG_RESET;
          end else begin
            if (wr_lo[g]) regs_q[g][7:0] <= i_wdata;
            if (wr_hi[g]) regs_q[g][15:8] <= i_wdata;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Correction and flash sequencer
  // ----------------------------------------------------------------------
  // Decimation field clipped at 16 so the window never overflows 17 bits
  wire [4:0] dec_eff = (i_decimation_setting > `BCA_DEC_MAX) ? `BCA_DEC_MAX :
                       i_decimation_setting;
  wire [16:0] avg_target = 17'(32'h1 << dec_eff);
  wire avg_done = i_sample && (avg_cnt_q + 17'h1 == avg_target);
  wire flash_done = (state_q == ST_FLASH) && (flash_tmr_q == 24'(FLASH_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      avg_cnt_q <= 17'h0;
      flash_tmr_q <= 24'h0;
      flash_write_counter_q <= 16'h0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          avg_cnt_q <= 17'h0;
          flash_tmr_q <= 24'h0;
          if (start_abc) state_q <= ST_ABC_SYNC;
          else if (start_restore || start_flash) state_q <= ST_FLASH;
        end
        ST_ABC_SYNC: begin
          if (i_data_ready) state_q <= ST_ABC_AVG;
        end
        ST_ABC_AVG: begin
          if (i_sample) avg_cnt_q <= avg_cnt_q + 17'h1;
          if (avg_done) state_q <= ST_ABC_LOAD;
        end
        ST_ABC_LOAD: begin
          state_q <= ST_FLASH;
        end
        ST_FLASH: begin
          flash_tmr_q <= flash_tmr_q + 24'h1;
          if (flash_done) begin
            flash_write_counter_q <= flash_write_counter_q + 16'h1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Calibrated rate output and one-cycle side effects
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_out_q <= 32'h0;
      data_clear_q <= 1'b0;
      dec_restart_q <= 1'b0;
      flash_write_q <= 1'b0;
    end else if (i_ce) begin
      rate_out_q <= start_restore ? 32'h0 : i_rate_cal + offset_full;
      data_clear_q <= start_restore;
      dec_restart_q <= (state_q == ST_ABC_SYNC) && i_data_ready;
      flash_write_q <= flash_done;
    end
  end

  // ----------------------------------------------------------------------
  // Alarms
  // ----------------------------------------------------------------------
  wire [15:0] diag_word = {i_diag_in[15:10], alarm_q, i_diag_in[7:0]};

  generate
    for (g = 0; g < 2; g++) begin : g_alarm
      logic [15:0] thr;
      logic [7:0] period;
      logic [3:0] src_sel;
      logic [15:0] src;
      logic roc;
      logic above;
      logic [7:0] win_q;
      logic [15:0] snap_q;
      assign thr = regs_q[2 + g];
      assign period = (regs_q[4 + g][7:0] < 8'h02) ? 8'h01 : regs_q[4 + g][7:0];
      assign src_sel = cfg[`BCA_CFG_SRC_LSB + 4*g +: 4];
      assign roc = cfg[`BCA_CFG_ROC_LSB + g];
      assign above = cfg[`BCA_CFG_POL_LSB + g];
      // Filtering only has meaning for the rate source
      assign src = (src_sel == `BCA_SRC_RATE) ?
                   (cfg[`BCA_CFG_FILT] ? i_rate_filt : rate_out_q[31:16]) :
                   (src_sel == `BCA_SRC_TEMP) ? i_temp :
                   (src_sel == `BCA_SRC_DIAG) ? diag_word : 16'h0;
      wire [16:0] delta = 17'({src[15], src} - {snap_q[15], snap_q});
      wire [16:0] delta_mag = delta[16] ? 17'(17'h0 - delta) : delta;
      wire [16:0] thr_mag = thr[15] ? 17'(17'h0 - {1'b1, thr}) : {1'b0, thr};
      wire stat_hit = above ? ($signed(src) > $signed(thr)) :
                              ($signed(src) < $signed(thr));
      wire dyn_hit = above ? (delta_mag > thr_mag) : (delta_mag < thr_mag);
      wire win_end = (win_q + 8'h01 >= period);
      wire enabled = (src_sel == `BCA_SRC_RATE) || (src_sel == `BCA_SRC_TEMP) ||
                     (src_sel == `BCA_SRC_DIAG);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          alarm_q[g] <= 1'b0;
          win_q <= 8'h0;
          snap_q <= 16'h0;
        end else if (i_ce && i_sample) begin
          if (!enabled) begin
            alarm_q[g] <= 1'b0;
            win_q <= 8'h0;
            snap_q <= src;
          end else if (!roc) begin
            alarm_q[g] <= stat_hit;
            snap_q <= src;
          end else if (win_end) begin
            alarm_q[g] <= dyn_hit;
            win_q <= 8'h0;
            snap_q <= src;
          end else begin
            win_q <= win_q + 8'h01;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // I/O line sharing
  // ----------------------------------------------------------------------
  wire alm_any = |alarm_q;
  wire alm_level = cfg[`BCA_CFG_PIN_POL] ? alm_any : !alm_any;
  logic [1:0] io_out_d;
  logic [1:0] io_oe_d;

  generate
    for (g = 0; g < 2; g++) begin : g_io
      wire dr_here = i_dready_en && (i_dready_sel == 1'(g));
      wire alm_here = cfg[`BCA_CFG_PIN_EN] && (cfg[`BCA_CFG_PIN_SEL] == 1'(g));
      // Data ready first, alarm second, general purpose last
      assign io_out_d[g] = dr_here ? i_dready_level :
                           alm_here ? alm_level : i_gpio_out[g];
      assign io_oe_d[g] = dr_here || alm_here || i_gpio_oe[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data and pin registers
  // ----------------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0;
    case (i_addr)
      `BCA_ADDR_FLASH_WRITE_COUNTER: rd_mux = flash_write_counter_q;
      `BCA_ADDR_RATE_LOW: rd_mux = rate_out_q[15:0];
      `BCA_ADDR_RATE_HIGH: rd_mux = rate_out_q[31:16];
      `BCA_ADDR_OFF_LOW: rd_mux = regs_q[0];
      `BCA_ADDR_OFF_HIGH: rd_mux = regs_q[1];
      `BCA_ADDR_ALM1_THR: rd_mux = regs_q[2];
      `BCA_ADDR_ALM2_THR: rd_mux = regs_q[3];
      `BCA_ADDR_ALM1_CNT: rd_mux = regs_q[4];
      `BCA_ADDR_ALM2_CNT: rd_mux = regs_q[5];
      `BCA_ADDR_ALM_CFG: rd_mux = regs_q[6];
      `BCA_ADDR_DIAG: rd_mux = diag_word;
      default: rd_mux = 16'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0;
      io_out_q <= 2'b00;
      io_oe_q <= 2'b00;
    end else if (i_ce) begin
      if (i_rd) rdata_q <= port_open ? rd_mux : 16'h0;
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_port_busy = abc_active || (state_q == ST_FLASH);
  assign o_rate_output_high = rate_out_q[31:16];
  assign o_rate_output_low = rate_out_q[15:0];
  assign o_data_clear = data_clear_q;
  assign o_dec_restart = dec_restart_q;
  assign o_flash_busy = (state_q == ST_FLASH);
  assign o_flash_write = flash_write_q;
  assign o_io_out = io_out_q;
  assign o_io_oe = io_oe_q;
  assign o_alarm_flags = alarm_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_abc_port_quiet: assert property (
    i_ce && abc_active && !load_offsets |=> $stable(regs_q[6]) && $stable(regs_q[2]))
    else $error("register changed during bias correction");
  a_abc_negates: assert property (
    i_ce && load_offsets |=> {regs_q[1], regs_q[0]} == 32'h0 - $past(rate_out_q))
    else $error("offset not the negated output");
  a_restore_clears: assert property (
    i_ce && start_restore |=> regs_q[0] == 16'h0 && regs_q[1] == 16'h0 && o_data_clear
      ##1 o_flash_busy)
    else $error("restore did not clear offsets");
  a_flash_counts: assert property (
    i_ce && flash_done |=> flash_write_counter_q == $past(flash_write_counter_q) + 16'h1 && o_flash_write)
    else $error("flash counter not advanced");
  a_cmd_selfclear: assert property (
    i_ce && flash_done |=> !o_port_busy && state_q == ST_IDLE)
    else $error("command did not clear");
  a_abc_starts: assert property (
    i_ce && start_abc |=> state_q == ST_ABC_SYNC && o_port_busy)
    else $error("bias correction did not start");
  a_alarm_disabled: assert property (
    i_ce && i_sample && cfg[11:8] == `BCA_SRC_OFF |=> !o_alarm_flags[0])
    else $error("disabled alarm raised");
  a_static_above: assert property (
    i_ce && i_sample && cfg[11:8] == `BCA_SRC_RATE && !cfg[6] && cfg[4] && !cfg[3] &&
    $signed(rate_out_q[31:16]) > $signed(regs_q[2]) |=> o_alarm_flags[0])
    else $error("static alarm missed");
  a_diag_flags: assert property (
    i_ce && i_rd && port_open && i_addr == `BCA_ADDR_DIAG |=>
      o_rdata[9:8] == $past(o_alarm_flags))
    else $error("diagnostic bits disagree with alarms");
  a_io_priority: assert property (
    i_ce && i_dready_en && !i_dready_sel |=> o_io_out[0] == $past(i_dready_level) && o_io_oe[0])
    else $error("data ready lost its line");
  a_rate_sum: assert property (
    i_ce && !start_restore |=> rate_out_q == $past(i_rate_cal) + $past(offset_full))
    else $error("rate output not offset sum");

endmodule : bca_core
`default_nettype wire

/* File: test/bca_host.sv */
// Host-side model of the register port: byte writes and word reads
`timescale 1ns/1ps
`default_nettype none
module bca_host (
  // Clock
  input wire logic i_clk,
  // Register port toward the block
  output logic o_wr,
  output logic o_rd,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [15:0] i_rdata
);
  initial begin
    {o_wr, o_rd, o_addr, o_wdata} = '0;
  end
  // Idle address and data are inverted so a stale value never passes for a new one
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask : wr_byte
  // Low half first; each half lands on its own
  task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
    wr_byte(a, d[7:0]);
    wr_byte(a | 7'h01, d[15:8]);
  endtask : wr_word
  // Read data is registered on the edge that takes the strobe
  task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b0, ~a};
    d = i_rdata;
  endtask : rd_word
endmodule : bca_host
`default_nettype wire

/* File: test/bca_core_tb.sv */
// Self-checking bench for the bias correction and alarm block
`timescale 1ns/1ps
`default_nettype none
module bca_core_tb;
  import bca_pkg::*;
  localparam int unsigned FLASH_N = 8;
  logic clk, rst_n, wr, rd, smp, drdy, dr_lvl, dr_en, dr_sel, dclr, drst, fbusy, fwr, pbusy;
  logic ce;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [4:0] dec;
  logic [31:0] cal, e32, s32;
  logic [15:0] filt, temp, diag, rdata, rq, ohi, olo, cfg, t1, t2;
  logic [1:0] gpo, gpoe, io_o, io_e, flags, f;
  logic [3:0] pe;
  int bad_count, compares, fl, n_fw, n_clr, n_rst;
  logic [6:0] ra [7] = '{7'h08, 7'h0a, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18};

  bca_core #(.FLASH_CYCLES(FLASH_N)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_port_busy(pbusy), .i_sample(smp),
    .i_data_ready(drdy), .i_decimation_setting(dec), .i_rate_cal(cal), .i_rate_filt(filt),
    .i_temp(temp), .i_diag_in(diag), .o_rate_output_high(ohi), .o_rate_output_low(olo),
    .o_data_clear(dclr), .o_dec_restart(drst), .o_flash_busy(fbusy), .o_flash_write(fwr),
    .i_dready_level(dr_lvl), .i_dready_en(dr_en), .i_dready_sel(dr_sel), .i_gpio_out(gpo),
    .i_gpio_oe(gpoe), .o_io_out(io_o), .o_io_oe(io_e), .o_alarm_flags(flags)
  );
  bca_host i_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is several hundred cycles
  initial begin
    #100us;
    bad_count++;
    results();
  end
  always @(posedge clk) begin
    n_fw <= n_fw + int'(fwr === 1'b1);
    n_clr <= n_clr + int'(dclr === 1'b1);
    n_rst <= n_rst + int'(drst === 1'b1);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    i_host.rd_word(a, rq);
    chk(rq, e);
  endtask : rdc
  task automatic pulse;
    @(negedge clk);
    smp = 1'b1;
    @(negedge clk);
    smp = 1'b0;
  endtask : pulse
  // One sample, then the flag register settles an edge later
  task automatic smp_chk(input logic [1:0] e);
    pulse();
    @(negedge clk);
    chk(16'(flags), 16'(e));
  endtask : smp_chk
  task automatic wait_fw(input int n);
    for (int k = 0; k < 40 && n_fw < n; k++) @(negedge clk);
    chk(16'(n_fw), 16'(n));
  endtask : wait_fw
  function automatic logic exp_flag(input logic [15:0] c, input int ch, input logic [15:0] t,
                                    input logic [1:0] pf);
    logic [3:0] s;
    logic signed [15:0] v;
    s = c[8 + 4 * ch +: 4];
    // Status source carries the flags as they stood before this sample
    v = (s == 4'h1) ? (c[3] ? filt : cal[31:16]) :
        (s == 4'h3) ? {diag[15:10], pf, diag[7:0]} : temp;
    if (s == 4'h0) return 1'b0;
    return c[4 + ch] ? (v > $signed(t)) : (v < $signed(t));
  endfunction : exp_flag
  function automatic logic [3:0] exp_pin(input logic [15:0] c, input logic [1:0] a);
    logic [1:0] o, e;
    logic dl, al;
    for (int l = 0; l < 2; l++) begin
      dl = dr_en && (dr_sel == l[0]);
      al = c[2] && (c[0] == l[0]);
      e[l] = dl || al || gpoe[l];
      o[l] = dl ? dr_lvl : (al ? (c[1] ? |a : ~|a) : gpo[l]);
    end
    return {e, o};
  endfunction : exp_pin

  initial begin
    {rst_n, smp, drdy, dr_lvl, dr_en, dr_sel, gpo, gpoe, dec} = '0;
    {cal, filt, temp, diag} = '0;
    ce = 1'b1;
    void'($urandom(32'he193));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    // ----------------------------------------------------------------
    // Reset values, readback, unmapped places
    // ----------------------------------------------------------------
    foreach (ra[i]) begin
      rdc(ra[i], 16'h0000);
      t1 = 16'($urandom);
      if (ra[i] inside {7'h14, 7'h16}) t1 = t1 & 16'h00ff;
      i_host.wr_word(ra[i], t1);
      rdc(ra[i], t1);
    end
    i_host.wr_word(7'h0c, 16'ha5a5);
    rdc(7'h0c, 16'h0000);
    rdc(7'h00, 16'h0000);
    // ----------------------------------------------------------------
    // Automatic correction at two averaging lengths
    // ----------------------------------------------------------------
    for (int j = 0; j < 2; j++) begin
      dec = 5'(2 + 2 * j);
      cal = $urandom;
      s32 = $urandom;
      i_host.wr_word(7'h08, s32[15:0]);
      i_host.wr_word(7'h0a, s32[31:16]);
      e32 = -(cal + s32);
      fl++;
      i_host.wr_byte(7'h28, 8'h01);
      chk(16'(pbusy), 16'h0001);
      i_host.wr_word(7'h0a, 16'h5a5a);
      rdc(7'h10, 16'h0000);
      @(negedge clk);
      drdy = 1'b1;
      @(negedge clk);
      drdy = 1'b0;
      repeat ((1 << dec) - 1) pulse();
      chk(16'(fbusy), 16'h0000);
      pulse();
      wait_fw(fl);
      chk(16'(n_rst), 16'(j + 1));
      chk(16'(pbusy), 16'h0000);
      rdc(7'h08, e32[15:0]);
      rdc(7'h0a, e32[31:16]);
      rdc(7'h00, 16'(fl));
      s32 = cal + e32;
      chk(ohi, s32[31:16]);
      chk(olo, s32[15:0]);
    end
    // Restore clears the offsets and flashes
    fl++;
    i_host.wr_byte(7'h28, 8'h02);
    wait_fw(fl);
    chk(16'(n_clr), 16'h0001);
    rdc(7'h08, 16'h0000);
    rdc(7'h0a, 16'h0000);
    rdc(7'h00, 16'(fl));
    // ----------------------------------------------------------------
    // Static alarms with random sources, thresholds and pin sharing
    // ----------------------------------------------------------------
    for (int i = 0; i < 24; i++) begin
      {cal, t1, t2, temp, filt, diag} = 112'({$urandom, $urandom, $urandom, $urandom});
      {dr_en, dr_sel, dr_lvl, gpo, gpoe} = 7'($urandom);
      cfg = {2'b00, 2'($urandom_range(3)), 2'b00, 2'($urandom_range(3)), 2'b00, 6'($urandom)};
      // Equal value must not trip a below-threshold alarm
      if (i == 0) {cfg[9:3], t1} = {7'b0100000, cal[31:16]};
      // Rate above the most negative threshold must trip
      if (i == 1) {cfg[11:3], t1, cal[31:16]} = {9'b000100010, 16'h8000, 16'h0001};
      i_host.wr_word(7'h10, t1);
      i_host.wr_word(7'h12, t2);
      i_host.wr_word(7'h18, cfg);
      f = {exp_flag(cfg, 1, t2, flags), exp_flag(cfg, 0, t1, flags)};
      smp_chk(f);
      rdc(7'h26, {diag[15:10], f, diag[7:0]});
      pe = exp_pin(cfg, f);
      chk(16'(io_e), 16'(pe[3:2]));
      chk(16'(io_o & pe[3:2]), 16'(pe[1:0] & pe[3:2]));
    end
    // Rate of change over one sample, counts 0 and 1
    for (int k = 0; k < 2; k++) begin
      cal = '0;
      i_host.wr_word(7'h14, 16'(k));
      i_host.wr_word(7'h10, 16'h0100);
      i_host.wr_word(7'h18, 16'h0150);
      pulse();
      smp_chk(2'b00);
      cal = 32'h0200_0000;
      smp_chk(2'b01);
      smp_chk(2'b00);
    end
    // Clock enable low: a write and a sample leave no trace
    @(negedge clk);
    ce = 1'b0;
    i_host.wr_word(7'h10, 16'hffff);
    cal = 32'h0400_0000;
    pulse();
    @(negedge clk);
    ce = 1'b1;
    rdc(7'h10, 16'h0100);
    chk(16'(flags), 16'h0000);
    // Restore beats flash in one byte; flash alone is counted too
    fl++;
    i_host.wr_byte(7'h28, 8'h0a);
    wait_fw(fl);
    chk(16'(n_clr), 16'h0002);
    fl++;
    i_host.wr_byte(7'h28, 8'h08);
    wait_fw(fl);
    chk(16'(n_clr), 16'h0002);
    rdc(7'h00, 16'(fl));
    // Hardware reset is the only way out of a running correction
    i_host.wr_byte(7'h28, 8'h01);
    @(negedge clk);
    drdy = 1'b1;
    @(negedge clk);
    drdy = 1'b0;
    pulse();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(16'(pbusy), 16'h0000);
    repeat (12) @(negedge clk);
    chk(16'(n_fw), 16'(fl));
    rdc(7'h10, 16'h0000);
    results();
  end
endmodule : bca_core_tb
`default_nettype wire
